// ===== bench/field_model.sv
// field side model: meter pulser and feedstock flow pulsers
`timescale 1ns/1ps
module field_model (
   // clock and valve state
   input wire logic clk,
   input wire logic slow_coil,
   input wire logic fast_coil,
   // high feedstock share, one bit per phase
   input wire logic [3:0] hi_pat,
   // pulser outputs
   output logic meter_pulse,
   output logic high_octane_input,
   output logic low_octane_input
);
   logic [1:0] ph_ff = 2'h0;
   logic flow;
   // no flow with both coils shut
   assign flow = slow_coil || fast_coil;
   always_ff @(posedge clk) ph_ff <= ph_ff + 2'h1;
   // meter count every second cycle
   assign meter_pulse = flow && ph_ff[0];
   assign high_octane_input = flow && hi_pat[ph_ff];
   assign low_octane_input = flow && !hi_pat[ph_ff];
endmodule

// ===== bench/fuel_dispense_sequencer_bench.sv
// self-checking bench for the dispense sequencer
`timescale 1ns/1ps
`include "fuel_seq_cfg.svh"
module fuel_dispense_sequencer_bench;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic handle_n = 1'b1;
   logic new_style = 1'b1;
   logic lim_hi = 1'b0;
   logic lim_lo = 1'b0;
   logic auth_remote = 1'b0;
   logic auth_local = 1'b0;
   logic price_load = 1'b0;
   logic preset_en = 1'b0;
   logic pos_select = 1'b0;
   logic price_jog = 1'b0;
   logic [2:0] grade_sel = 3'h0;
   logic [15:0] preset_amount = 16'h0000;
   logic [3:0] hi_pat = 4'h3;
   logic meter_pulse, hi_in, lo_in, slow_coil, fast_coil, more_hi, more_lo;
   logic authorized, prices_loaded;
   logic [`FDS_GRADES-1:0] pump_relay;
   logic [1:0] display_mode, price_digit;
   logic [15:0] delivered;
   logic [3:0] error_code;
   logic [2:0] price_position;
   logic [`FDS_POSITIONS*`FDS_PRICE_DIGITS*4-1:0] unit_prices;
   int failures = 0;
   int checked = 0;
   int cyc = 0;
   int t0;
   ////////////////////////////////////////////////////////////////////////////////
   // short counts keep the run small
   fuel_dispense_sequencer #(.PUMP_DELAY_CYC(32'h28), .TEST_PHASE_CYC(32'h8),
      .JOG_STEP_CYC(32'h6), .BLEND_WIN_CYC(32'h14)) u_dut (
      .clk, .sys_rst, .handle_n, .grade_sel, .new_style, .blend_limit_hi(lim_hi),
      .blend_limit_lo(lim_lo), .auth_remote, .auth_local, .price_load, .meter_pulse,
      .high_octane_input(hi_in), .low_octane_input(lo_in), .preset_en, .preset_amount,
      .blend_target_pct(7'h32), .pos_select, .price_jog, .pump_relay, .slow_coil,
      .fast_coil, .blend_more_high(more_hi), .blend_more_low(more_lo), .display_mode,
      .delivered, .error_code, .authorized, .prices_loaded, .price_position,
      .price_digit, .unit_prices);
   field_model u_field (.clk, .slow_coil, .fast_coil, .hi_pat, .meter_pulse,
      .high_octane_input(hi_in), .low_octane_input(lo_in));
   ////////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial forever #25 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         failures = failures + 1;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // look once the registers have settled
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] act, input logic [15:0] exp, input string what);
      checked++;
      if (act !== exp) begin
         failures++;
         $display("[ERR] %0t %s: got %h want %h", $time, what, act, exp);
      end
   endtask
   task automatic lever(input logic v);
      @(posedge clk) handle_n <= v;
   endtask
   task automatic jog(input int n);
      @(posedge clk) price_jog <= 1'b1;
      repeat (n) @(posedge clk);
      price_jog <= 1'b0;
   endtask
   task automatic sel();
      @(posedge clk) pos_select <= 1'b1;
      @(posedge clk) pos_select <= 1'b0;
      step(1);
   endtask
   task automatic phase(input logic [1:0] nxt);
      logic [1:0] cur;
      int n;
      cur = display_mode;
      for (n = 0; display_mode === cur && n < 20; n++) step(1);
      chk(16'(display_mode), 16'(nxt), "phase");
      chk(16'(n), 16'h0008, "phase len");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // authorized, no prices: lift refused
   task automatic t_refuse();
      @(posedge clk) auth_remote <= 1'b1;
      @(posedge clk) auth_remote <= 1'b0;
      lever(1'b0);
      step(12);
      chk(16'(pump_relay), 16'h0000, "pump");
      chk(16'(display_mode), 16'h0000, "display");
      lever(1'b1);
      step(3);
   endtask
   // two digits, locked edit, position wrap
   task automatic t_price();
      sel();
      chk(16'(price_position), 16'h0001, "closure 1");
      jog(3);
      jog(15);
      step(2);
      chk(unit_prices[15:0], 16'h0031, "digits");
      chk(16'(price_digit), 16'h0001, "digit");
      chk(16'(prices_loaded), 16'h0001, "loaded");
      lever(1'b0);
      jog(3);
      step(2);
      chk(unit_prices[15:0], 16'h0031, "lever up");
      lever(1'b1);
      step(3);
      // the lift put the selector back on the sale display
      repeat (7) sel();
      chk(16'(price_position), 16'h0000, "closure 7");
   endtask
   // preset sale of 40 counts
   task automatic t_preset();
      @(posedge clk) auth_remote <= 1'b1;
      preset_en <= 1'b1;
      preset_amount <= 16'h0028;
      grade_sel <= 3'h2;
      @(posedge clk) auth_remote <= 1'b0;
      step(1);
      chk(16'(authorized), 16'h0001, "auth");
      lever(1'b0);
      step(1);
      t0 = cyc;
      chk(16'(pump_relay), 16'h0004, "pump");
      chk(16'(display_mode), 16'(`FDS_DISP_EIGHTS), "eights");
      phase(`FDS_DISP_BLANK);
      phase(`FDS_DISP_ZEROS);
      phase(`FDS_DISP_SALE);
      for (int i = 0; i < 60 && slow_coil !== 1'b1; i++) step(1);
      chk(16'(cyc - t0), 16'h0028, "delay");
      for (int i = 0; i < 40 && fast_coil !== 1'b1; i++) step(1);
      chk(16'(slow_coil), 16'h0000, "slow off");
      chk(delivered, 16'h000a, "pulses");
      for (int i = 0; i < 80 && fast_coil !== 1'b0; i++) step(1);
      chk(16'(slow_coil), 16'h0001, "slow back");
      chk(16'(delivered >= 16'h001e && delivered < 16'h0028), 16'h0001, "prestop");
      for (int i = 0; i < 80 && slow_coil !== 1'b0; i++) step(1);
      chk(delivered, 16'h0028, "final");
      chk(16'(pump_relay), 16'h0000, "pump off");
      chk(16'(error_code), 16'h0000, "blend");
      lever(1'b1);
      preset_en <= 1'b0;
      step(3);
   endtask
   // old style, lever down, reset mid-sale, price load
   task automatic t_old();
      @(posedge clk) new_style <= 1'b0;
      grade_sel <= 3'h0;
      lever(1'b0);
      step(1);
      chk(16'(pump_relay), 16'h0001, "old pump");
      lever(1'b1);
      step(2);
      chk(16'({pump_relay, slow_coil, fast_coil}), 16'h0000, "down");
      lever(1'b0);
      @(posedge clk) sys_rst <= 1'b1;
      handle_n <= 1'b1;
      step(2);
      chk(16'({pump_relay, prices_loaded}), 16'h0000, "reset");
      @(posedge clk) sys_rst <= 1'b0;
      new_style <= 1'b1;
      price_load <= 1'b1;
      @(posedge clk) price_load <= 1'b0;
      step(1);
      chk(16'(prices_loaded), 16'h0001, "load");
   endtask
   // low feedstock only, limits as given
   task automatic t_fault(input logic [1:0] lim, input logic [3:0] code);
      logic seen;
      seen = 1'b0;
      @(posedge clk) lim_hi <= lim[1];
      lim_lo <= lim[0];
      auth_local <= 1'b1;
      hi_pat <= 4'h0;
      lever(1'b0);
      step(2);
      for (int i = 0; i < 600 && error_code === 4'h0; i++) begin
         step(1);
         seen = seen | more_hi;
      end
      step(1);
      chk(16'(error_code), 16'(code), "code");
      chk(16'({pump_relay, slow_coil, fast_coil}), 16'h0000, "off");
      if (code == `FDS_ERR_RATIO) chk(16'(seen), 16'h0001, "motor");
      lever(1'b1);
      lim_hi <= 1'b0;
      lim_lo <= 1'b0;
      step(3);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      step(1);
      chk(16'({pump_relay, slow_coil, fast_coil, display_mode}), 16'h0000, "reset");
      t_refuse();
      t_price();
      t_preset();
      t_old();
      t_fault(2'b00, `FDS_ERR_RATIO);
      t_fault(2'b10, `FDS_ERR_LIMIT_BLEND);
      t_fault(2'b11, `FDS_ERR_LIMIT_CHECK);
      wrap_up();
   end
endmodule

// ===== bench/fuel_seq_sva.sv
// port checker for the dispense sequencer
`timescale 1ns/1ps
`include "fuel_seq_cfg.svh"
module fuel_seq_sva #(
   parameter logic [31:0] PUMP_DELAY_CYC = 32'h00000028
) (
   // clock and reset
   input logic clk,
   input logic sys_rst,
   // field inputs
   input logic handle_n,
   input logic auth_remote,
   input logic auth_local,
   input logic meter_pulse,
   input logic [15:0] preset_amount,
   // outputs
   input logic [`FDS_GRADES-1:0] pump_relay,
   input logic slow_coil,
   input logic fast_coil,
   input logic [1:0] display_mode,
   input logic [15:0] delivered,
   input logic [3:0] error_code,
   input logic authorized,
   input logic prices_loaded,
   input logic [`FDS_POSITIONS*`FDS_PRICE_DIGITS*4-1:0] unit_prices
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////////
   logic [31:0] pump_age_ff;
   logic [3:0] slow_cnt_ff;
   // pump on-time, pulses with only slow open
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pump_age_ff <= 32'h0;
         slow_cnt_ff <= 4'h0;
      end else begin
         pump_age_ff <= (pump_relay != '0) ? pump_age_ff + 32'h1 : 32'h0;
         slow_cnt_ff <= (slow_coil && !fast_coil) ? slow_cnt_ff + {3'h0, meter_pulse} : 4'h0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // never disabled: reset is what it watches
   property p_rst_off;
      disable iff (1'b0) sys_rst |=> pump_relay == '0 && !slow_coil && !fast_coil
         && display_mode == `FDS_DISP_SALE && error_code == `FDS_ERR_NONE && !prices_loaded;
   endproperty
   a_rst_off: assert property (p_rst_off) else $error("reset");
   property p_lift;
      $rose(|pump_relay) |-> !$past(handle_n);
   endproperty
   a_lift: assert property (p_lift) else $error("lift");
   property p_ready;
      $rose(display_mode == `FDS_DISP_EIGHTS) |-> $past(prices_loaded)
         && ($past(authorized) || $past(auth_remote) || $past(auth_local));
   endproperty
   a_ready: assert property (p_ready) else $error("ready");
   property p_blank;
      $changed(display_mode) && display_mode == `FDS_DISP_BLANK
         |-> $past(display_mode) == `FDS_DISP_EIGHTS;
   endproperty
   a_blank: assert property (p_blank) else $error("blank");
   property p_zeros;
      $changed(display_mode) && display_mode == `FDS_DISP_ZEROS
         |-> $past(display_mode) == `FDS_DISP_BLANK;
   endproperty
   a_zeros: assert property (p_zeros) else $error("zeros");
   // one cycle slack: the delay is approximate
   property p_slow_delay;
      $rose(slow_coil) && !$past(fast_coil) |-> pump_age_ff + 32'h1 >= PUMP_DELAY_CYC
         && pump_age_ff <= PUMP_DELAY_CYC + 32'h1;
   endproperty
   a_slow_delay: assert property (p_slow_delay) else $error("delay");
   property p_ten;
      $rose(fast_coil) |-> !slow_coil && slow_cnt_ff == `FDS_SLOW_PULSES;
   endproperty
   a_ten: assert property (p_ten) else $error("ten");
   property p_prestop;
      $fell(fast_coil) && slow_coil |-> delivered + 16'h000a >= preset_amount
         && delivered < preset_amount;
   endproperty
   a_prestop: assert property (p_prestop) else $error("prestop");
   property p_final;
      $fell(slow_coil) && !fast_coil && !$past(handle_n) && error_code == `FDS_ERR_NONE
         |-> delivered >= preset_amount && pump_relay == '0;
   endproperty
   a_final: assert property (p_final) else $error("final");
   property p_lower;
      $rose(handle_n) |-> ##[1:2] (pump_relay == '0 && !slow_coil && !fast_coil);
   endproperty
   a_lower: assert property (p_lower) else $error("lower");
   property p_err_off;
      $rose(error_code != `FDS_ERR_NONE) |-> ##[0:1] (pump_relay == '0 && !slow_coil
         && !fast_coil);
   endproperty
   a_err_off: assert property (p_err_off) else $error("error");
   property p_price_lock;
      !handle_n |=> $stable(unit_prices);
   endproperty
   a_price_lock: assert property (p_price_lock) else $error("lock");
   // main scenarios
   c_fast: cover property ($rose(fast_coil));
   c_ratio: cover property ($rose(error_code == `FDS_ERR_RATIO));
   c_price: cover property ($changed(unit_prices));
endmodule

bind fuel_dispense_sequencer fuel_seq_sva #(.PUMP_DELAY_CYC(PUMP_DELAY_CYC)) u_sva (
   .clk, .sys_rst, .handle_n, .auth_remote, .auth_local, .meter_pulse, .preset_amount,
   .pump_relay, .slow_coil, .fast_coil, .display_mode, .delivered, .error_code,
   .authorized, .prices_loaded, .unit_prices
);

// ===== rtl/fuel_dispense_sequencer.sv
// dispense sequencer: lever, pump, valves, blend control and price entry
//
// Contract
// - handle input pulled low starts a sale
// - new style: pump on at lift if authorized
// - old style: pump on at lift always
// - self test: eights, blank, zeros on display
// - check blend limit switches during reset cycle
// - slow coil on four seconds after pump
// - ten pulses: fast coil on, slow off
// - preset: back to slow just before target
// - preset: slow off at final amount
// - handle back high ends the sale
// - measure feedstock flows, steer blend motor
// - unreachable blend ratio ends sale with error
// - limit closed with bad ratio: blend error
// - no reset without prices and authorization
// - price edits only with levers off
// - selector picks position, jog alters price
// - jog held cycles digit, presses step up
`timescale 1ns/1ps
`include "fuel_seq_cfg.svh"
module fuel_dispense_sequencer #(
   parameter logic [31:0] PUMP_DELAY_CYC = `FDS_PUMP_DELAY_CYC,
   parameter logic [31:0] TEST_PHASE_CYC = `FDS_TEST_PHASE_CYC,
   parameter logic [31:0] JOG_STEP_CYC = `FDS_JOG_STEP_CYC,
   parameter logic [31:0] BLEND_WIN_CYC = `FDS_BLEND_WIN_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // field switches
   input wire logic handle_n,
   input wire logic [2:0] grade_sel,
   input wire logic new_style,
   input wire logic blend_limit_hi,
   input wire logic blend_limit_lo,
   // authorization and price loading
   input wire logic auth_remote,
   input wire logic auth_local,
   input wire logic price_load,
   // meter and feedstock pulsers
   input wire logic meter_pulse,
   input wire logic high_octane_input,
   input wire logic low_octane_input,
   // preset and blend target
   input wire logic preset_en,
   input wire logic [15:0] preset_amount,
   input wire logic [6:0] blend_target_pct,
   // price entry buttons
   input wire logic pos_select,
   input wire logic price_jog,
   // relays and coils
   output logic [`FDS_GRADES-1:0] pump_relay,
   output logic slow_coil,
   output logic fast_coil,
   output logic blend_more_high,
   output logic blend_more_low,
   // status
   output logic [1:0] display_mode,
   output logic [15:0] delivered,
   output logic [3:0] error_code,
   output logic authorized,
   output logic prices_loaded,
   output logic [2:0] price_position,
   output logic [1:0] price_digit,
   output logic [`FDS_POSITIONS*`FDS_PRICE_DIGITS*4-1:0] unit_prices
);

   fuel_seq_pkg::seq_state_t state_ff;
   fuel_seq_pkg::seq_state_t nxt_state;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic lift;
      logic lower;
      logic ready;
      logic dispensing;
      logic jog_step;
      logic [15:0] pre_stop;
      logic [8:0] total;
      logic [15:0] have;
      logic [15:0] want;
      logic [15:0] tol;
      logic [4:0] idx;
      logic [3:0] digit;
      lift = 1'b0;
      lower = 1'b0;
      ready = 1'b0;
      dispensing = 1'b0;
      jog_step = 1'b0;
      pre_stop = 16'h0000;
      total = 9'h000;
      have = 16'h0000;
      want = 16'h0000;
      tol = 16'h0000;
      idx = 5'h00;
      digit = 4'h0;
      nxt_state = state_ff;
      nxt_state.hs_prev = handle_n;
      nxt_state.sel_prev = pos_select;
      nxt_state.jog_prev = price_jog;
      lift = state_ff.hs_prev & ~handle_n;
      lower = ~state_ff.hs_prev & handle_n;
      ready = state_ff.prices_ok & (state_ff.authorized | auth_remote | auth_local);
      dispensing = (state_ff.st == fuel_seq_pkg::ST_SLOW_START) |
                   (state_ff.st == fuel_seq_pkg::ST_FAST) |
                   (state_ff.st == fuel_seq_pkg::ST_SLOW_END);
      pre_stop = (preset_amount > `FDS_PRESTOP_MARGIN) ?
                 preset_amount - `FDS_PRESTOP_MARGIN : 16'h0000;
      // latches: an incoming authorization or load beats any clear this cycle
      if (auth_remote | auth_local) begin
         nxt_state.authorized = 1'b1;
      end
      if (price_load) begin
         nxt_state.prices_ok = 1'b1;
      end
      // pump-to-slow delay runs off the system clock while the relay is on
      if (state_ff.pump_on && state_ff.pump_tmr != 32'hffffffff) begin
         nxt_state.pump_tmr = state_ff.pump_tmr + 32'h00000001;
      end
      // meter counting while a coil is open
      if (dispensing && meter_pulse) begin
         nxt_state.delivered = state_ff.delivered + 16'h0001;
      end
      case (state_ff.st)
         fuel_seq_pkg::ST_IDLE: begin
            if (lift) begin
               nxt_state.grade_lat = grade_sel;
               nxt_state.pump_tmr = 32'h00000000;
               nxt_state.pos = 3'h0;
               if (!new_style) begin
                  nxt_state.pump_on = 1'b1;
               end
               if (ready) begin
                  // sale resets: consume a one-shot authorization
                  nxt_state.pump_on = 1'b1;
                  nxt_state.authorized = auth_remote | auth_local;
                  nxt_state.st = fuel_seq_pkg::ST_TEST_EIGHTS;
                  nxt_state.disp = `FDS_DISP_EIGHTS;
                  nxt_state.tmr = 32'h00000000;
                  nxt_state.delivered = 16'h0000;
                  nxt_state.err = `FDS_ERR_NONE;
                  nxt_state.bad_cnt = 4'h0;
               end else begin
                  nxt_state.st = fuel_seq_pkg::ST_REFUSED;
               end
            end else if (handle_n && state_ff.hs_prev) begin
               // price entry, lever must be down the whole time
               if (pos_select && !state_ff.sel_prev) begin
                  nxt_state.pos = (state_ff.pos == 3'(`FDS_POSITIONS)) ?
                                  3'h0 : state_ff.pos + 3'h1;
                  nxt_state.dig = 2'h0;
                  nxt_state.jog_first = 1'b1;
               end else if (state_ff.pos != 3'h0 && price_jog) begin
                  if (!state_ff.jog_prev) begin
                     // each new press after the first since selection moves one digit up
                     jog_step = 1'b1;
                     nxt_state.jog_first = 1'b0;
                     if (!state_ff.jog_first) begin
                        nxt_state.dig = state_ff.dig + 2'h1;
                     end
                     nxt_state.tmr = 32'h00000000;
                  end else if (state_ff.tmr >= JOG_STEP_CYC - 32'h00000001) begin
                     jog_step = 1'b1;
                     nxt_state.tmr = 32'h00000000;
                  end else begin
                     nxt_state.tmr = state_ff.tmr + 32'h00000001;
                  end
                  if (jog_step) begin
                     idx = 5'(state_ff.pos - 3'h1) * 5'(`FDS_PRICE_DIGITS) +
                           5'(nxt_state.dig);
                     digit = state_ff.prices[idx*4 +: 4];
                     nxt_state.prices[idx*4 +: 4] = (digit >= 4'h9) ?
                                                    4'h0 : digit + 4'h1;
                     nxt_state.prices_ok = 1'b1;
                  end
               end
            end
         end
         fuel_seq_pkg::ST_TEST_EIGHTS, fuel_seq_pkg::ST_TEST_BLANK,
         fuel_seq_pkg::ST_TEST_ZEROS: begin
            nxt_state.tmr = state_ff.tmr + 32'h00000001;
            if (blend_limit_hi && blend_limit_lo) begin
               // both ends closed at once means a stuck or shorted switch
               nxt_state.st = fuel_seq_pkg::ST_ERR;
               nxt_state.err = `FDS_ERR_LIMIT_CHECK;
               nxt_state.disp = `FDS_DISP_SALE;
               nxt_state.pump_on = 1'b0;
            end else if (state_ff.tmr >= TEST_PHASE_CYC - 32'h00000001) begin
               nxt_state.tmr = 32'h00000000;
               if (state_ff.st == fuel_seq_pkg::ST_TEST_EIGHTS) begin
                  nxt_state.st = fuel_seq_pkg::ST_TEST_BLANK;
                  nxt_state.disp = `FDS_DISP_BLANK;
               end else if (state_ff.st == fuel_seq_pkg::ST_TEST_BLANK) begin
                  nxt_state.st = fuel_seq_pkg::ST_TEST_ZEROS;
                  nxt_state.disp = `FDS_DISP_ZEROS;
               end else begin
                  nxt_state.st = fuel_seq_pkg::ST_PUMP_WAIT;
                  nxt_state.disp = `FDS_DISP_SALE;
               end
            end
         end
         fuel_seq_pkg::ST_PUMP_WAIT: begin
            // a self test longer than the delay just opens the coil late
            if (state_ff.pump_tmr >= PUMP_DELAY_CYC - 32'h00000001) begin
               nxt_state.slow = 1'b1;
               nxt_state.pulses = 4'h0;
               nxt_state.win_tmr = 32'h00000000;
               nxt_state.hi_cnt = 8'h00;
               nxt_state.lo_cnt = 8'h00;
               nxt_state.st = fuel_seq_pkg::ST_SLOW_START;
            end
         end
         fuel_seq_pkg::ST_SLOW_START: begin
            if (meter_pulse) begin
               nxt_state.pulses = state_ff.pulses + 4'h1;
               if (state_ff.pulses == `FDS_SLOW_PULSES - 4'h1) begin
                  nxt_state.slow = 1'b0;
                  nxt_state.fast = 1'b1;
                  nxt_state.st = fuel_seq_pkg::ST_FAST;
               end
            end
         end
         fuel_seq_pkg::ST_FAST: begin
            if (preset_en && state_ff.delivered >= pre_stop) begin
               nxt_state.fast = 1'b0;
               nxt_state.slow = 1'b1;
               nxt_state.st = fuel_seq_pkg::ST_SLOW_END;
            end
         end
         fuel_seq_pkg::ST_SLOW_END: begin
            if (state_ff.delivered >= preset_amount) begin
               nxt_state.slow = 1'b0;
               nxt_state.pump_on = 1'b0;
               nxt_state.mot_hi = 1'b0;
               nxt_state.mot_lo = 1'b0;
               nxt_state.st = fuel_seq_pkg::ST_DONE;
            end
         end
         fuel_seq_pkg::ST_REFUSED, fuel_seq_pkg::ST_DONE, fuel_seq_pkg::ST_ERR: begin
            nxt_state.slow = 1'b0;
            nxt_state.fast = 1'b0;
         end
         default: begin
            nxt_state.st = fuel_seq_pkg::ST_IDLE;
         end
      endcase
      // blend loop: count feedstock pulses per window, then steer the valve
      if (dispensing) begin
         if (high_octane_input && state_ff.hi_cnt != 8'hff) begin
            nxt_state.hi_cnt = state_ff.hi_cnt + 8'h01;
         end
         if (low_octane_input && state_ff.lo_cnt != 8'hff) begin
            nxt_state.lo_cnt = state_ff.lo_cnt + 8'h01;
         end
         nxt_state.win_tmr = state_ff.win_tmr + 32'h00000001;
         if (state_ff.win_tmr >= BLEND_WIN_CYC - 32'h00000001) begin
            nxt_state.win_tmr = 32'h00000000;
            nxt_state.hi_cnt = 8'h00;
            nxt_state.lo_cnt = 8'h00;
            total = {1'b0, state_ff.hi_cnt} + {1'b0, state_ff.lo_cnt};
            have = 16'(state_ff.hi_cnt) * 16'h0064;
            want = 16'(blend_target_pct) * 16'(total);
            tol = `FDS_BLEND_TOL * 16'(total);
            if (total != 9'h000) begin
               if (17'(have) + 17'(tol) < 17'(want)) begin
                  nxt_state.mot_hi = 1'b1;
                  nxt_state.mot_lo = 1'b0;
                  nxt_state.bad_cnt = state_ff.bad_cnt + 4'h1;
               end else if (17'(have) > 17'(want) + 17'(tol)) begin
                  nxt_state.mot_hi = 1'b0;
                  nxt_state.mot_lo = 1'b1;
                  nxt_state.bad_cnt = state_ff.bad_cnt + 4'h1;
               end else begin
                  nxt_state.mot_hi = 1'b0;
                  nxt_state.mot_lo = 1'b0;
                  nxt_state.bad_cnt = 4'h0;
               end
               if (nxt_state.bad_cnt != 4'h0 &&
                   ((nxt_state.mot_hi && blend_limit_hi) ||
                    (nxt_state.mot_lo && blend_limit_lo))) begin
                  nxt_state.err = `FDS_ERR_LIMIT_BLEND;
                  nxt_state.st = fuel_seq_pkg::ST_ERR;
               end else if (nxt_state.bad_cnt >= `FDS_BLEND_BAD_MAX) begin
                  nxt_state.err = `FDS_ERR_RATIO;
                  nxt_state.st = fuel_seq_pkg::ST_ERR;
               end
               if (nxt_state.st == fuel_seq_pkg::ST_ERR) begin
                  nxt_state.slow = 1'b0;
                  nxt_state.fast = 1'b0;
                  nxt_state.pump_on = 1'b0;
                  nxt_state.mot_hi = 1'b0;
                  nxt_state.mot_lo = 1'b0;
               end
            end
         end
      end
      // lever lowered: everything off, sale complete, any state
      if (lower && state_ff.st != fuel_seq_pkg::ST_IDLE) begin
         nxt_state.st = fuel_seq_pkg::ST_IDLE;
         nxt_state.pump_on = 1'b0;
         nxt_state.slow = 1'b0;
         nxt_state.fast = 1'b0;
         nxt_state.mot_hi = 1'b0;
         nxt_state.mot_lo = 1'b0;
         nxt_state.disp = `FDS_DISP_SALE;
      end
      // one relay per grade, picked by the grade latched at lift
      for (int g = 0; g < `FDS_GRADES; g++) begin
         nxt_state.pumps[g] = nxt_state.pump_on && (nxt_state.grade_lat == 3'(g));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; relays and coils off from reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff <= '0;
         state_ff.st <= fuel_seq_pkg::ST_IDLE;
         state_ff.hs_prev <= 1'b1;
         state_ff.jog_first <= 1'b1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register
   assign pump_relay = state_ff.pumps;
   assign slow_coil = state_ff.slow;
   assign fast_coil = state_ff.fast;
   assign blend_more_high = state_ff.mot_hi;
   assign blend_more_low = state_ff.mot_lo;
   assign display_mode = state_ff.disp;
   assign delivered = state_ff.delivered;
   assign error_code = state_ff.err;
   assign authorized = state_ff.authorized;
   assign prices_loaded = state_ff.prices_ok;
   assign price_position = state_ff.pos;
   assign price_digit = state_ff.dig;
   assign unit_prices = state_ff.prices;

endmodule

// ===== rtl/fuel_seq_cfg.svh
// constants for the dispense sequencer: sizes, timing, codes
`ifndef FUEL_SEQ_CFG_SVH
`define FUEL_SEQ_CFG_SVH
// cycle counts at the 20 MHz system clock
`define FDS_PUMP_DELAY_CYC 32'h04c4b400
`define FDS_TEST_PHASE_CYC 32'h00989680
`define FDS_JOG_STEP_CYC 32'h004c4b40
`define FDS_BLEND_WIN_CYC 32'h001e8480
`define FDS_SLOW_PULSES 4'ha
`define FDS_PRESTOP_MARGIN 16'h000a
`define FDS_BLEND_TOL 16'h0005
`define FDS_BLEND_BAD_MAX 4'h8
`define FDS_GRADES 5
`define FDS_POSITIONS 6
`define FDS_PRICE_DIGITS 4
`define FDS_DISP_SALE 2'h0
`define FDS_DISP_EIGHTS 2'h1
`define FDS_DISP_BLANK 2'h2
`define FDS_DISP_ZEROS 2'h3
`define FDS_ERR_NONE 4'h0
`define FDS_ERR_LIMIT_CHECK 4'h2
`define FDS_ERR_RATIO 4'h3
`define FDS_ERR_LIMIT_BLEND 4'h4
`endif

// ===== rtl/fuel_seq_pkg.sv
// types of the dispense sequencer
`include "fuel_seq_cfg.svh"
package fuel_seq_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_REFUSED, ST_TEST_EIGHTS, ST_TEST_BLANK, ST_TEST_ZEROS,
      ST_PUMP_WAIT, ST_SLOW_START, ST_FAST, ST_SLOW_END, ST_DONE, ST_ERR
   } sale_state_t;

   typedef struct packed {
      sale_state_t st;
      logic hs_prev;
      logic sel_prev;
      logic jog_prev;
      logic jog_first;
      logic authorized;
      logic prices_ok;
      logic pump_on;
      logic slow;
      logic fast;
      logic [`FDS_GRADES-1:0] pumps;
      logic [2:0] grade_lat;
      logic [1:0] disp;
      logic [31:0] pump_tmr;
      logic [31:0] tmr;
      logic [31:0] win_tmr;
      logic [3:0] pulses;
      logic [15:0] delivered;
      logic [7:0] hi_cnt;
      logic [7:0] lo_cnt;
      logic [3:0] bad_cnt;
      logic mot_hi;
      logic mot_lo;
      logic [3:0] err;
      logic [2:0] pos;
      logic [1:0] dig;
      logic [`FDS_POSITIONS*`FDS_PRICE_DIGITS*4-1:0] prices;
   } seq_state_t;
endpackage
